// File: pkg/imu_status_pkg.sv
/*
 * constants for the status and sample time-stamp register group:
 * register indices and byte addresses, field positions, reset values
 * and the bus encodings the slave decodes.
 * assumes one clock domain and a 32-bit ahb-lite register bus.
 */
package imu_status_pkg;

    ////////////////////////////////////////////////////////////////////
    // register indices (printed offsets) and byte addresses
    localparam int ADDR_W = 12;
    localparam logic [7:0] OUT_STATUS_IDX = 8'h16;
    localparam logic [7:0] MISC_STATUS_IDX = 8'h17;
    localparam logic [7:0] SAMPLE_COUNT_IDX = 8'h18;
    localparam logic [7:0] MODE_CTRL_IDX = 8'h40;
    localparam logic [7:0] CMD_CTRL_IDX = 8'h41;
    // byte address is four times the index
    localparam logic [11:0] OUT_STATUS_ADDR = {2'h0, OUT_STATUS_IDX, 2'h0};
    localparam logic [11:0] MISC_STATUS_ADDR = {2'h0, MISC_STATUS_IDX, 2'h0};
    localparam logic [11:0] SAMPLE_COUNT_ADDR = {2'h0, SAMPLE_COUNT_IDX, 2'h0};
    localparam logic [11:0] MODE_CTRL_ADDR = {2'h0, MODE_CTRL_IDX, 2'h0};
    localparam logic [11:0] CMD_CTRL_ADDR = {2'h0, CMD_CTRL_IDX, 2'h0};

    ////////////////////////////////////////////////////////////////////
    // output data status: ready flag at sensor index, overrun at +4
    localparam int NUM_SENSORS = 4;
    localparam int ACCEL_IDX = 0;
    localparam int GYRO_IDX = 1;
    localparam int MAG_IDX = 2;
    localparam int FUSION_IDX = 3;
    localparam int OVERRUN_OFS = 4;
    // misc status fields
    localparam int MOTION_WAKE_BIT = 2;
    localparam int FIFO_READY_BIT = 1;
    localparam int CMD_COMPLETE_BIT = 0;
    // mode control field
    localparam int SYNC_SAMPLE_BIT = 0;

    ////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;

    // freeze state of the sensor output registers (gray along the path)
    typedef enum logic [1:0] {
        OUT_LIVE = 2'h0,
        OUT_FROZEN = 2'h1
    } out_state_type;

endpackage

// File: pkg/sensor_flag_if.sv
/*
 * carrier for one sensor's new-data and overrun flag pair.
 * assumes both ends sit on the same clock.
 */
interface sensor_flag_if;
    logic sample;   // one-cycle pulse: fresh data written to output
    logic clear;    // one-cycle pulse: host read the status register
    logic ready;    // new data since last status read
    logic overrun;  // data overwritten before it was read

    modport owner (input sample, input clear, output ready, output overrun);
    modport user (output sample, output clear, input ready, input overrun);
endinterface

// File: src/sensor_flag_pair.sv
/*
 * new-data and overrun flags of one sensor stream.
 * assumes sample and clear are single-cycle pulses on the same clock.
 */
module sensor_flag_pair (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // flag carrier
    sensor_flag_if.owner flg
);
    import imu_status_pkg::*;

    logic ready_r;
    logic overrun_r;

    ////////////////////////////////////////////////////////////////////
    // new data: set wins over the read clear so no sample is lost
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ready_r <= 1'b0;
        end else if (flg.sample) begin
            ready_r <= 1'b1;
        end else if (flg.clear) begin
            ready_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // overrun: fresh data lands while the previous was still unread
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            overrun_r <= 1'b0;
        end else if (flg.sample && ready_r && !flg.clear) begin
            overrun_r <= 1'b1;
        end else if (flg.clear) begin
            overrun_r <= 1'b0;
        end
    end

    assign flg.ready = ready_r;
    assign flg.overrun = overrun_r;

    AST_OVERRUN_NEEDS_UNREAD: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $rose(overrun_r) |-> $past(ready_r) && $past(flg.sample))
        else $error("overrun raised without unread data");
endmodule

// File: src/imu_status_regs.sv
/*
 * status and sample time-stamp register group with its ahb-lite slave,
 * sync-sample freeze control and the magnetometer sample hold.
 * assumes sensor events arrive as one-cycle pulses on i_ref_clk and
 * that the output data block reports the last byte read as a pulse.
 */
// Chosen here: the AHB-Lite register port.
//
// Summary of operation
// - fusion overwritten unread sets status bit 7
// - magnetometer overwritten unread sets status bit 6
// - gyroscope overwritten unread sets status bit 5
// - accelerometer overwritten unread sets status bit 4
// - bit 3 shows new fusion result
// - bit 2 shows magnetometer data valid
// - slow magnetometer repeats last valid sample
// - bit 1 shows new gyroscope data
// - bit 0 shows new accelerometer data
// - misc bit 2 set on motion wake
// - misc bit 1 set while fifo ready
// - misc bit 0 signals command completion
// - counter steps once per fastest sample set
// - counter wraps from 0xFF to zero
// - sync mode status read freezes, second_interrupt_line low
module imu_status_regs #(
    parameter int MAG_W = 48
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [11:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // sensor events (same clock, one-cycle pulses)
    input wire logic i_accel_sample,
    input wire logic i_gyro_sample,
    input wire logic i_mag_sample,
    input wire logic [MAG_W-1:0] i_mag_data,
    input wire logic i_mag_enabled,
    input wire logic i_fusion_result,
    input wire logic i_output_tick,
    input wire logic i_fastest_sample,
    // companion blocks
    input wire logic i_motion_event,
    input wire logic i_fifo_ready,
    input wire logic i_command_done,
    input wire logic i_last_byte_read,
    // outputs to the data path and pins
    output logic [MAG_W-1:0] o_mag_out,
    output logic o_output_freeze,
    output logic o_second_interrupt_line,
    output logic o_command_start,
    output logic [7:0] o_command_code
);
    import imu_status_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // declarations
    sensor_flag_if flag_bus [NUM_SENSORS] ();  // one carrier per sensor
    logic [NUM_SENSORS-1:0] sample_vec;        // fresh data pulses
    logic [NUM_SENSORS-1:0] ready_vec;         // new-data flags
    logic [NUM_SENSORS-1:0] overrun_vec;       // overrun flags
    logic status_read;      // address phase of a status read taken
    logic addr_take;        // any valid address phase taken
    logic wr_pend_r;        // write data phase pending
    logic [11:0] wr_addr_r; // address of the pending write
    logic sync_mode_r;      // sync-sample level mode selected
    logic motion_r;         // motion wake seen
    logic fifo_r;           // fifo holds data
    logic cmd_done_r;       // command finished
    logic mag_valid_r;      // held magnetometer sample is valid
    logic [MAG_W-1:0] mag_hold_r;  // last magnetometer sample, taken enabled or not
    logic [7:0] count_r;    // sample time stamp
    logic [7:0] out_status; // assembled output data status
    logic [7:0] misc_status;
    out_state_type out_state_r;

    // nonseq or seq address phase the slave accepts, of any hsize
    function automatic logic take(input logic sel, input logic [1:0] tr,
                                  input logic rdy);
        take = sel && rdy && (tr == HTRANS_NONSEQ || tr == HTRANS_SEQ);
    endfunction

    assign addr_take = take(i_hsel, i_htrans, i_hready);
    assign status_read = addr_take && !i_hwrite &&
                         (i_haddr == OUT_STATUS_ADDR);

    ////////////////////////////////////////////////////////////////////
    // per-sensor flag pairs
    assign sample_vec[ACCEL_IDX] = i_accel_sample;
    assign sample_vec[GYRO_IDX] = i_gyro_sample;
    assign sample_vec[MAG_IDX] = i_mag_sample;
    assign sample_vec[FUSION_IDX] = i_fusion_result;

    for (genvar s = 0; s < NUM_SENSORS; s++) begin : g_flag
        assign flag_bus[s].sample = sample_vec[s];
        assign flag_bus[s].clear = status_read;
        assign ready_vec[s] = flag_bus[s].ready;
        assign overrun_vec[s] = flag_bus[s].overrun;
        sensor_flag_pair u_pair (
            .i_ref_clk(i_ref_clk),
            .i_sys_rst(i_sys_rst),
            .flg(flag_bus[s])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // register images; bit 2 is validity, not a new-data flag
    always_comb begin
        out_status = STATUS_RESET;
        out_status[OVERRUN_OFS+FUSION_IDX] = overrun_vec[FUSION_IDX];
        out_status[OVERRUN_OFS+MAG_IDX] = overrun_vec[MAG_IDX];
        out_status[OVERRUN_OFS+GYRO_IDX] = overrun_vec[GYRO_IDX];
        out_status[OVERRUN_OFS+ACCEL_IDX] = overrun_vec[ACCEL_IDX];
        out_status[FUSION_IDX] = ready_vec[FUSION_IDX];
        out_status[MAG_IDX] = mag_valid_r;
        out_status[GYRO_IDX] = ready_vec[GYRO_IDX];
        out_status[ACCEL_IDX] = ready_vec[ACCEL_IDX];
        // reserved upper bits stay at the reset value
        misc_status = STATUS_RESET;
        misc_status[MOTION_WAKE_BIT] = motion_r;
        misc_status[FIFO_READY_BIT] = fifo_r;
        misc_status[CMD_COMPLETE_BIT] = cmd_done_r;
    end

    ////////////////////////////////////////////////////////////////////
    // bus slave: zero wait, always okay
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_hreadyout <= 1'b1;
            o_hresp <= HRESP_OKAY;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= HRESP_OKAY;
        end
    end

    // read data captured at the address phase, shown in the data phase;
    // capture and clear share an edge so nothing set later is lost
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_hrdata <= RDATA_RESET;
        end else if (addr_take && !i_hwrite) begin
            if (i_haddr == OUT_STATUS_ADDR) begin
                o_hrdata <= {24'h00_0000, out_status};
            end else if (i_haddr == MISC_STATUS_ADDR) begin
                o_hrdata <= {24'h00_0000, misc_status};
            end else if (i_haddr == SAMPLE_COUNT_ADDR) begin
                o_hrdata <= {24'h00_0000, count_r};
            end else if (i_haddr == MODE_CTRL_ADDR) begin
                o_hrdata <= {31'h0000_0000, sync_mode_r};
            end else if (i_haddr == CMD_CTRL_ADDR) begin
                o_hrdata <= {24'h00_0000, o_command_code};
            end else begin
                o_hrdata <= RDATA_RESET;  // unmapped reads as zero
            end
        end
    end

    // remember a write address phase until its data phase
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else if (i_hready) begin
            wr_pend_r <= addr_take && i_hwrite;
            wr_addr_r <= i_haddr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software-written control
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync_mode_r <= 1'b0;
        end else if (wr_pend_r && wr_addr_r == MODE_CTRL_ADDR) begin
            sync_mode_r <= i_hwdata[SYNC_SAMPLE_BIT];
        end
    end

    // command write launches a command; a pulse for the engine
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_command_code <= CMD_RESET;
            o_command_start <= 1'b0;
        end else begin
            o_command_start <= wr_pend_r && wr_addr_r == CMD_CTRL_ADDR;
            if (wr_pend_r && wr_addr_r == CMD_CTRL_ADDR) begin
                o_command_code <= i_hwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // misc status; completion set wins over the clear of a new command
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            motion_r <= 1'b0;
            fifo_r <= 1'b0;
            cmd_done_r <= 1'b0;
        end else begin
            if (i_motion_event) begin
                motion_r <= 1'b1;
            end else if (addr_take && !i_hwrite &&
                         i_haddr == MISC_STATUS_ADDR) begin
                motion_r <= 1'b0;
            end
            fifo_r <= i_fifo_ready;
            if (i_command_done) begin
                cmd_done_r <= 1'b1;
            end else if (wr_pend_r && wr_addr_r == CMD_CTRL_ADDR) begin
                cmd_done_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // magnetometer hold: slow magnetometer repeats its last sample at
    // every output tick while valid and not frozen; validity drops when the sensor is disabled
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mag_hold_r <= '0;
            mag_valid_r <= 1'b0;
        end else begin
            if (i_mag_sample) begin
                mag_hold_r <= i_mag_data;
            end
            if (!i_mag_enabled) begin
                mag_valid_r <= 1'b0;
            end else if (i_mag_sample) begin
                mag_valid_r <= 1'b1;
            end
        end
    end

    // output register follows the hold each tick unless frozen or the hold is not valid
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_mag_out <= '0;
        end else if (i_output_tick && !o_output_freeze && mag_valid_r) begin
            o_mag_out <= mag_hold_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sample time stamp, natural 8-bit wrap
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            count_r <= COUNT_RESET;
        end else if (i_fastest_sample) begin
            count_r <= count_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // freeze control: a status read in level mode stops output updates
    // until the last output byte is read
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            out_state_r <= OUT_LIVE;
            o_output_freeze <= 1'b0;
        end else begin
            case (out_state_r)
                OUT_LIVE: begin
                    if (sync_mode_r && status_read) begin
                        out_state_r <= OUT_FROZEN;
                        o_output_freeze <= 1'b1;
                    end
                end
                OUT_FROZEN: begin
                    if (i_last_byte_read) begin
                        out_state_r <= OUT_LIVE;
                        o_output_freeze <= 1'b0;
                    end
                end
                default: begin
                    out_state_r <= OUT_LIVE;
                    o_output_freeze <= 1'b0;
                end
            endcase
        end
    end

    // second interrupt: tick pulse in edge mode; in level mode high on
    // new data while live, low from the status read until released
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_second_interrupt_line <= 1'b0;
        end else if (!sync_mode_r) begin
            o_second_interrupt_line <= i_output_tick;
        end else if (status_read || out_state_r == OUT_FROZEN) begin
            o_second_interrupt_line <= 1'b0;
        end else begin
            o_second_interrupt_line <= |ready_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_level_read;
        sync_mode_r && out_state_r == OUT_LIVE && status_read;
    endsequence
    sequence s_held_low;
        o_output_freeze && !o_second_interrupt_line;
    endsequence

    AST_FUSION_OVR: assert property (
        i_fusion_result && ready_vec[FUSION_IDX] && !status_read
        |=> out_status[7]) else $error("fusion overrun missed");
    AST_MAG_OVR: assert property (
        i_mag_sample && ready_vec[MAG_IDX] && !status_read
        |=> out_status[6]) else $error("mag overrun missed");
    AST_GYRO_OVR: assert property (
        i_gyro_sample && ready_vec[GYRO_IDX] && !status_read
        |=> out_status[5]) else $error("gyro overrun missed");
    AST_ACCEL_OVR: assert property (
        i_accel_sample && ready_vec[ACCEL_IDX] && !status_read
        |=> out_status[4]) else $error("accel overrun missed");
    AST_FUSION_READY: assert property (
        i_fusion_result |=> out_status[3]) else $error("fusion ready lost");
    AST_MAG_VALID: assert property (
        !i_mag_enabled |=> !out_status[2]) else $error("mag valid stuck");
    AST_MAG_REPEAT: assert property (
        i_output_tick && !o_output_freeze && mag_valid_r
        |=> o_mag_out == $past(mag_hold_r)) else $error("mag not repeated");
    AST_GYRO_READY: assert property (
        i_gyro_sample |=> out_status[1]) else $error("gyro ready lost");
    AST_ACCEL_READY: assert property (
        i_accel_sample |=> out_status[0]) else $error("accel ready lost");
    AST_MOTION: assert property (
        i_motion_event |=> misc_status[2]) else $error("motion missed");
    AST_FIFO: assert property (
        ##1 misc_status[1] == $past(i_fifo_ready)) else $error("fifo bit");
    AST_CMD_DONE: assert property (
        i_command_done |=> misc_status[0]) else $error("cmd done missed");
    AST_COUNT_STEP: assert property (
        i_fastest_sample |=> count_r == $past(count_r) + 8'h01)
        else $error("count did not step");
    AST_COUNT_WRAP: assert property (
        i_fastest_sample && count_r == 8'hFF |=> count_r == 8'h00)
        else $error("count did not wrap");
    AST_RESERVED: assert property (
        misc_status[7:3] == 5'h00) else $error("reserved bits set");
    AST_FREEZE: assert property (
        s_level_read |=> s_held_low [*1] ##0 s_held_low)
        else $error("level read did not freeze");
    AST_READ_CLEAR: assert property (
        status_read && !i_accel_sample |=> !out_status[0])
        else $error("read did not clear ready");
endmodule

// File: verification/imu_host_model.sv
/* host model: single-word ahb-lite master for the register group.
   assumes one clock and one slave whose hreadyout is the bus hready. */
module imu_host_model
    import imu_status_pkg::*;
(
    // clock and bus answer
    input wire logic i_ref_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    // bus request
    output logic o_hsel,
    output logic [11:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata,
    // wait ran out of its bound
    output logic o_hung
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////
    // idle bus at time zero; word transfers only
    initial begin
        {o_hsel, o_haddr, o_htrans, o_hwrite, o_hwdata, o_hung} = '0;
        o_hsize = 3'h2;
    end
    // bounded wait for hready high at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (i_hready !== 1'b1 && n < 64);
        if (i_hready !== 1'b1) o_hung = 1'b1;
    endtask
    // address phase held until taken, then data phase until answered
    task automatic xfer(input logic w, input logic [11:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge i_ref_clk);
        o_hsel <= 1'b1;
        o_haddr <= a;
        o_hwrite <= w;
        o_htrans <= HTRANS_NONSEQ;
        wait_ready();
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= wd;
        wait_ready();
        rd = i_hrdata;
    endtask
endmodule

// File: verification/imu_status_and_sample_count_tb_top.sv
/* bench for the status and time-stamp registers: events driven here,
   registers read through the host model, compared with a bench model. */
module imu_status_and_sample_count_tb_top
    import imu_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, men = 1'b0, fifo = 1'b0, lbr = 1'b0;
    logic [7:0] ev = 8'h00, code;
    logic [47:0] mdat = 48'h0, mout, held = 48'h0, mexp = 48'h0;
    logic hsel, hwrite, hready, hresp, hung, frz_o, second_interrupt_line, cstart;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    // bench model: ready and overrun per sensor, misc flags, count
    logic [3:0] rdy = 4'h0, ovr = 4'h0;
    logic magv = 0, mot = 0, cmd = 0, frz = 0, mode = 0;
    int cnt = 0, miscompares = 0, comparisons = 0;
    logic [15:0] seed = 16'h000F;

    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    imu_status_regs #(.MAG_W(48)) dut (.i_ref_clk(clk), .i_sys_rst(rst),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_accel_sample(ev[0]), .i_gyro_sample(ev[1]),
        .i_mag_sample(ev[2]), .i_mag_data(mdat), .i_mag_enabled(men),
        .i_fusion_result(ev[3]), .i_output_tick(ev[4]),
        .i_fastest_sample(ev[5]), .i_motion_event(ev[6]),
        .i_fifo_ready(fifo), .i_command_done(ev[7]),
        .i_last_byte_read(lbr), .o_mag_out(mout), .o_output_freeze(frz_o),
        .o_second_interrupt_line(second_interrupt_line), .o_command_start(cstart),
        .o_command_code(code));
    imu_host_model host (.i_ref_clk(clk), .i_hready(hready),
        .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
        .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
        .o_hwdata(hwdata), .o_hung(hung));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task test_done;
        if (miscompares == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string n, input logic [47:0] e, input logic [47:0] g);
        comparisons++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", n, e, g);
            miscompares++;
        end
    endtask
    task rc(input logic [11:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, rd);
        chk($sformatf("reg %h", a), {16'h0, e}, {16'h0, rd});
        chk("hresp", {47'h0, HRESP_OKAY}, {47'h0, hresp});
    endtask
    // status read clears ready and overrun; in sync mode it freezes
    task rs;
        rc(OUT_STATUS_ADDR, {24'h0, ovr, rdy[3], magv, rdy[1:0]});
        rdy = 4'h0;
        ovr = 4'h0;
        if (mode) frz = 1'b1;
    endtask
    task rm;
        rc(MISC_STATUS_ADDR, {29'h0, mot, fifo, cmd});
        mot = 1'b0;
    endtask
    // one-cycle event pulse, then the model takes the same edge
    task pulse(input logic [7:0] e);
        @(posedge clk);
        ev <= e;
        seed = lfsr(seed);
        mdat <= {3{seed}};
        @(posedge clk);
        ev <= 8'h00;
        for (int s = 0; s < 4; s++) if (e[s]) begin
            ovr[s] = ovr[s] | rdy[s];
            rdy[s] = 1'b1;
        end
        if (e[2] && men) begin
            magv = 1'b1;
            held = mdat;
        end
        if (e[4] && magv && !frz) mexp = held;
        if (e[5]) cnt = (cnt + 1) % 256;
        mot = mot | e[6];
        cmd = cmd | e[7];
    endtask
    task see;
        @(negedge clk);
        chk("mag_out", mexp, mout);
        chk("freeze", {47'h0, frz}, {47'h0, frz_o});
    endtask
    task release_freeze;
        @(posedge clk);
        lbr <= 1'b1;
        @(posedge clk);
        lbr <= 1'b0;
        frz = 1'b0;
        see();
    endtask
    ////////////////////////////////////////////////////////////////////
    always @(posedge clk) if (hung) begin
        miscompares++;
        test_done();
    end
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        test_done();
    end
    initial begin
        logic [7:0] e;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        men <= 1'b1;
        rs();
        rc(SAMPLE_COUNT_ADDR, 32'h0);
        // random event mix; mag sample and tick kept apart
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            e = seed[7:0];
            if (e[2]) e[4] = 1'b0;
            pulse(e);
            see();
            chk("second_interrupt_line edge", {47'h0, e[4]}, {47'h0, second_interrupt_line});
            if (i % 4 == 3) begin
                rs();
                rm();
                rc(SAMPLE_COUNT_ADDR, 32'(cnt));
            end
        end
        host.xfer(1'b1, OUT_STATUS_ADDR, 32'hFF, rd);
        rs();
        repeat (257) pulse(8'h20);
        rc(SAMPLE_COUNT_ADDR, 32'(cnt));
        rc(12'h004, 32'h0);
        fifo <= 1'b1;
        // let the level settle so the expected value sees it
        @(posedge clk);
        rm();
        fifo <= 1'b0;
        pulse(8'h80);
        rm();
        seed = lfsr(seed);
        host.xfer(1'b1, CMD_CTRL_ADDR, {24'h0, seed[7:0]}, rd);
        cmd = 1'b0;
        @(negedge clk) chk("cmd_code", {40'h0, seed[7:0]}, {40'h0, code});
        chk("cmd_start", 48'h1, {47'h0, cstart});
        rm();
        men <= 1'b0;
        repeat (2) @(posedge clk);
        magv = 1'b0;
        rs();
        men <= 1'b1;
        pulse(8'h04);
        repeat (2) pulse(8'h10);
        see();
        host.xfer(1'b1, MODE_CTRL_ADDR, 32'h1, rd);
        mode = 1'b1;
        rs();
        see();
        chk("second_interrupt_line", 48'h0, {47'h0, second_interrupt_line});
        pulse(8'h04);
        pulse(8'h10);
        see();
        chk("second_interrupt_line", 48'h0, {47'h0, second_interrupt_line});
        release_freeze();
        repeat (2) @(negedge clk);
        chk("second_interrupt_line", {47'h0, |rdy}, {47'h0, second_interrupt_line});
        rs();
        release_freeze();
        pulse(8'h10);
        see();
        test_done();
    end
endmodule
